// ===== shared/cds_pkg.sv
/*
  Constants for the drive-signal setup register bank: register pointers,
  reset values, field positions, state codes and timing counts.
  Assumes a single 50 MHz clock domain; no import, every use is scoped.
*/
package cds_pkg;

  // register pointers
  localparam logic [7:0] PTR_DRIVE_SETUP = 8'h09;
  localparam logic [7:0] PTR_CONV_CONFIG = 8'h0A;

  // values after reset, and the read value of unmapped pointers
  localparam logic [7:0] RST_DRIVE_SETUP = 8'h03;
  localparam logic [7:0] RST_CONV_CONFIG = 8'hA0;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // drive_signal_setup field positions
  localparam int unsigned BIT_CLOCK_HALVING = 7;
  localparam int unsigned BIT_DRIVE_ALL = 6;
  localparam int unsigned BIT_PIN_B_TRUE = 5;
  localparam int unsigned BIT_PIN_B_INV = 4;
  localparam int unsigned BIT_PIN_A_TRUE = 3;
  localparam int unsigned BIT_PIN_A_INV = 2;
  localparam int unsigned BIT_LEVEL_HI = 1;
  localparam int unsigned BIT_LEVEL_LO = 0;

  // serial slave address, arbitrary value
  localparam logic [6:0] SLAVE_ADDR = 7'h48;

  // clock periods per modulator tick at full rate; doubled when halving
  localparam logic [3:0] MOD_DIV_BASE = 4'h4;
  localparam logic [3:0] MOD_DIV_HALVED = 4'h8;

  // modulator ticks per conversion; halving doubles the tick, not the count
  localparam logic [11:0] CAP_CONV_TICKS = 12'h040;
  localparam logic [11:0] VT_CONV_TICKS = 12'h080;

  // bits per serial byte
  localparam logic [3:0] BYTE_BITS = 4'h8;

  typedef enum logic [8:0] {
    CDS_IDLE = 9'h001,
    CDS_ADDR = 9'h002,
    CDS_ACK_ADDR = 9'h004,
    CDS_PTR = 9'h008,
    CDS_ACK_PTR = 9'h010,
    CDS_WDATA = 9'h020,
    CDS_ACK_WDATA = 9'h040,
    CDS_RDATA = 9'h080,
    CDS_RACK = 9'h100
  } cds_state_t;

endpackage : cds_pkg

// ===== logic/cds_drive_gen.sv
/*
  Drive-signal and modulator clock generator.
  Assumes halve_i comes from a register on the same clock.
*/
`timescale 1ns/1ns
module cds_drive_gen (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic halve_i,
  output logic phase_o,
  output logic mod_tick_o
);

  logic [3:0] div_q;
  logic [3:0] limit;

  // halving doubles the tick period, so drive and modulator both slow down
  assign limit = halve_i ? cds_pkg::MOD_DIV_HALVED : cds_pkg::MOD_DIV_BASE;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_q <= 4'h0;
      mod_tick_o <= 1'b0;
    end else if (ce_i) begin
      if (div_q >= limit - 4'h1) begin
        div_q <= 4'h0;
        mod_tick_o <= 1'b1;
      end else begin
        div_q <= div_q + 4'h1;
        mod_tick_o <= 1'b0;
      end
    end
  end

  // drive square wave flips once per modulator tick
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_o <= 1'b0;
    end else if (ce_i && div_q >= limit - 4'h1) begin
      phase_o <= ~phase_o;
    end
  end

endmodule : cds_drive_gen

// ===== logic/cds_top.sv
/*
  Drive-signal setup register bank with two-wire serial slave, conversion
  timer and drive pin control.
  Assumes scl/sda are asynchronous pins and conversion requests come from
  logic on clock_i; the pad resolves the open-drain sda from sda_oe_o.
*/
`timescale 1ns/1ns
module cds_top (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic conv_start_i,
  input wire logic conv_vt_i,
  output logic conv_busy_o,
  output logic conv_done_o,
  output logic drv_a_o,
  output logic drv_a_oe_o,
  output logic drv_b_o,
  output logic drv_b_oe_o,
  output logic [1:0] drive_level_o,
  output logic [7:0] converter_config_o
);

  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  logic scl_rise, scl_fall, start_det, stop_det;
  cds_pkg::cds_state_t st_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q, ptr_q;
  logic rw_q, nack_q, wr_stb;
  logic [7:0] drive_setup_q, rd_next;
  logic phase, mod_tick;
  logic [11:0] tick_cnt_q;
  logic conv_is_vt_q, drive_active;

  function automatic logic [7:0] rd_mux(input logic [7:0] ptr, input logic [7:0] setup,
                                        input logic [7:0] cfg);
    if (ptr == cds_pkg::PTR_DRIVE_SETUP) begin
      rd_mux = setup;
    end else if (ptr == cds_pkg::PTR_CONV_CONFIG) begin
      rd_mux = cfg;
    end else begin
      rd_mux = cds_pkg::RD_UNMAPPED;
    end
  endfunction : rd_mux

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else if (ce_i) begin
      scl_s1_q <= scl_i;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  assign scl_rise = scl_s2_q & ~scl_s3_q;
  assign scl_fall = ~scl_s2_q & scl_s3_q;
  assign start_det = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;
  assign stop_det = scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q;
  assign wr_stb = (st_q == cds_pkg::CDS_WDATA) && scl_fall && (cnt_q == cds_pkg::BYTE_BITS);
  assign rd_next = rd_mux(ptr_q, drive_setup_q, converter_config_o);

  // serial slave: address, pointer, then data bytes with auto-increment
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= cds_pkg::CDS_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (ce_i) begin
      if (start_det) begin
        st_q <= cds_pkg::CDS_ADDR;
        cnt_q <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (stop_det) begin
        st_q <= cds_pkg::CDS_IDLE;
        sda_oe_o <= 1'b0;
      end else if (scl_rise) begin
        unique case (st_q)
          cds_pkg::CDS_ADDR, cds_pkg::CDS_PTR, cds_pkg::CDS_WDATA: begin
            sh_q <= {sh_q[6:0], sda_s2_q};
            cnt_q <= cnt_q + 4'h1;
          end
          cds_pkg::CDS_RDATA: cnt_q <= cnt_q + 4'h1;
          cds_pkg::CDS_RACK: nack_q <= sda_s2_q;
          default: ;
        endcase
      end else if (scl_fall) begin
        unique case (st_q)
          cds_pkg::CDS_ADDR: begin
            if (cnt_q == cds_pkg::BYTE_BITS) begin
              if (sh_q[7:1] == cds_pkg::SLAVE_ADDR) begin
                st_q <= cds_pkg::CDS_ACK_ADDR;
                rw_q <= sh_q[0];
                sda_oe_o <= 1'b1;
              end else begin
                st_q <= cds_pkg::CDS_IDLE;
              end
            end
          end
          cds_pkg::CDS_ACK_ADDR: begin
            cnt_q <= 4'h0;
            if (rw_q) begin
              st_q <= cds_pkg::CDS_RDATA;
              sh_q <= rd_next;
              sda_oe_o <= ~rd_next[7];
            end else begin
              st_q <= cds_pkg::CDS_PTR;
              sda_oe_o <= 1'b0;
            end
          end
          cds_pkg::CDS_PTR: begin
            if (cnt_q == cds_pkg::BYTE_BITS) begin
              ptr_q <= sh_q;
              st_q <= cds_pkg::CDS_ACK_PTR;
              sda_oe_o <= 1'b1;
            end
          end
          cds_pkg::CDS_ACK_PTR, cds_pkg::CDS_ACK_WDATA: begin
            st_q <= cds_pkg::CDS_WDATA;
            cnt_q <= 4'h0;
            sda_oe_o <= 1'b0;
          end
          cds_pkg::CDS_WDATA: begin
            if (cnt_q == cds_pkg::BYTE_BITS) begin
              ptr_q <= ptr_q + 8'h01;
              st_q <= cds_pkg::CDS_ACK_WDATA;
              sda_oe_o <= 1'b1;
            end
          end
          cds_pkg::CDS_RDATA: begin
            if (cnt_q == cds_pkg::BYTE_BITS) begin
              st_q <= cds_pkg::CDS_RACK;
              ptr_q <= ptr_q + 8'h01;
              sda_oe_o <= 1'b0;
            end else begin
              sh_q <= {sh_q[6:0], 1'b0};
              sda_oe_o <= ~sh_q[6];
            end
          end
          cds_pkg::CDS_RACK: begin
            cnt_q <= 4'h0;
            if (nack_q) begin
              st_q <= cds_pkg::CDS_IDLE;
            end else begin
              st_q <= cds_pkg::CDS_RDATA;
              sh_q <= rd_next;
              sda_oe_o <= ~rd_next[7];
            end
          end
          cds_pkg::CDS_IDLE: ;
          default: st_q <= cds_pkg::CDS_IDLE;
        endcase
      end
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sda_o <= 1'b0;
    end else if (ce_i) begin
      sda_o <= 1'b0;
    end
  end

  // register bank; unmapped pointers swallow writes
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      drive_setup_q <= cds_pkg::RST_DRIVE_SETUP;
      converter_config_o <= cds_pkg::RST_CONV_CONFIG;
    end else if (ce_i && wr_stb) begin
      if (ptr_q == cds_pkg::PTR_DRIVE_SETUP) begin
        drive_setup_q <= sh_q;
      end
      if (ptr_q == cds_pkg::PTR_CONV_CONFIG) begin
        converter_config_o <= sh_q;
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      drive_level_o <= cds_pkg::RST_DRIVE_SETUP[1:0];
    end else if (ce_i) begin
      drive_level_o <= {drive_setup_q[cds_pkg::BIT_LEVEL_HI], drive_setup_q[cds_pkg::BIT_LEVEL_LO]};
    end
  end

  cds_drive_gen u_drive_gen (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .halve_i(drive_setup_q[cds_pkg::BIT_CLOCK_HALVING]),
    .phase_o(phase),
    .mod_tick_o(mod_tick)
  );

  // conversion length counted in modulator ticks, so halving doubles it
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conv_busy_o <= 1'b0;
      conv_done_o <= 1'b0;
      conv_is_vt_q <= 1'b0;
      tick_cnt_q <= 12'h000;
    end else if (ce_i) begin
      conv_done_o <= 1'b0;
      if (!conv_busy_o) begin
        if (conv_start_i) begin
          conv_busy_o <= 1'b1;
          conv_is_vt_q <= conv_vt_i;
          tick_cnt_q <= 12'h000;
        end
      end else if (mod_tick) begin
        if (tick_cnt_q == (conv_is_vt_q ? cds_pkg::VT_CONV_TICKS : cds_pkg::CAP_CONV_TICKS)
                          - 12'h001) begin
          conv_busy_o <= 1'b0;
          conv_done_o <= 1'b1;
        end else begin
          tick_cnt_q <= tick_cnt_q + 12'h001;
        end
      end
    end
  end

  // capacitive conversions always drive; voltage ones only with drive-all set
  assign drive_active = conv_busy_o &
                        (~conv_is_vt_q | drive_setup_q[cds_pkg::BIT_DRIVE_ALL]);

  // both enables set is a host error; true polarity then wins
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      drv_b_o <= 1'b0;
      drv_b_oe_o <= 1'b0;
    end else if (ce_i) begin
      drv_b_oe_o <= drive_active & (drive_setup_q[cds_pkg::BIT_PIN_B_TRUE] |
                                    drive_setup_q[cds_pkg::BIT_PIN_B_INV]);
      if (!drive_active) begin
        drv_b_o <= 1'b0;
      end else if (drive_setup_q[cds_pkg::BIT_PIN_B_TRUE]) begin
        drv_b_o <= phase;
      end else if (drive_setup_q[cds_pkg::BIT_PIN_B_INV]) begin
        drv_b_o <= ~phase;
      end else begin
        drv_b_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      drv_a_o <= 1'b0;
      drv_a_oe_o <= 1'b0;
    end else if (ce_i) begin
      drv_a_oe_o <= drive_active & (drive_setup_q[cds_pkg::BIT_PIN_A_TRUE] |
                                    drive_setup_q[cds_pkg::BIT_PIN_A_INV]);
      if (!drive_active) begin
        drv_a_o <= 1'b0;
      end else if (drive_setup_q[cds_pkg::BIT_PIN_A_TRUE]) begin
        drv_a_o <= phase;
      end else if (drive_setup_q[cds_pkg::BIT_PIN_A_INV]) begin
        drv_a_o <= ~phase;
      end else begin
        drv_a_o <= 1'b0;
      end
    end
  end

endmodule : cds_top

// ===== verif/cds_top_sva.sv
/* Port-level checker for cds_top.
   Assumes one clock domain, asynchronous active-low reset. */
`timescale 1ns/1ns
module cds_top_sva (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic conv_start_i,
  input wire logic conv_busy_o,
  input wire logic conv_done_o,
  input wire logic drv_a_o,
  input wire logic drv_a_oe_o,
  input wire logic drv_b_o,
  input wire logic drv_b_oe_o,
  input wire logic [1:0] drive_level_o,
  input wire logic [7:0] converter_config_o
);
  logic [10:0] busy_cnt_q;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_cnt_q <= 11'h000;
    end else begin
      busy_cnt_q <= conv_busy_o ? busy_cnt_q + 11'h001 : 11'h000;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  AST_RESET_VALUES: assert property (
    $rose(nrst_i) |-> drive_level_o == 2'h3 && converter_config_o == 8'hA0)
    else $error("register reset values wrong");
  AST_START_BUSY: assert property (
    ce_i && conv_start_i && !conv_busy_o |=> conv_busy_o)
    else $error("conversion not taken");
  AST_DONE_PULSE: assert property (conv_done_o |=> !conv_done_o)
    else $error("done longer than one cycle");
  AST_BUSY_END: assert property ($fell(conv_busy_o) |-> conv_done_o)
    else $error("busy fell without done");
  // window covers full rate capacitive up to halved voltage channel
  AST_CONV_TIME: assert property (
    conv_done_o |-> busy_cnt_q >= 11'h0F0 && busy_cnt_q <= 11'h410)
    else $error("conversion length out of range");
  AST_PINS_IDLE: assert property (
    !$past(conv_busy_o) |-> !drv_a_oe_o && !drv_b_oe_o)
    else $error("drive pin enabled outside conversion");
  AST_A_QUIET: assert property (!drv_a_oe_o |-> !drv_a_o)
    else $error("pin A value while undriven");
  AST_B_QUIET: assert property (!drv_b_oe_o |-> !drv_b_o)
    else $error("pin B value while undriven");
  AST_PHASE_HOLD: assert property (
    drv_a_oe_o && $past(drv_a_oe_o) && $changed(drv_a_o)
    |=> (!drv_a_oe_o || $stable(drv_a_o))[*3])
    else $error("drive phase too short");
endmodule : cds_top_sva
bind cds_top cds_top_sva u_sva (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i),
  .conv_start_i(conv_start_i), .conv_busy_o(conv_busy_o), .conv_done_o(conv_done_o),
  .drv_a_o(drv_a_o), .drv_a_oe_o(drv_a_oe_o), .drv_b_o(drv_b_o), .drv_b_oe_o(drv_b_oe_o),
  .drive_level_o(drive_level_o), .converter_config_o(converter_config_o));

// ===== verif/cds_host_model.sv
/* Host model: two-wire bus master, open-drain data line.
   Assumes the device pulls data low only through sda_oe_i. */
`timescale 1ns/1ns
module cds_host_model (
  input wire logic clock_i,
  input wire logic sda_oe_i,
  output logic scl_o,
  output logic sda_o
);
  logic pull_q = 1'b0;
  initial scl_o = 1'b1;
  // pulled-up wire: low if either party pulls
  assign sda_o = !(pull_q || sda_oe_i);
  task automatic wt(input int n);
    repeat (n) @(negedge clock_i);
  endtask : wt
  // data moves only mid-low, clear of clock edges, for the synchronisers
  task automatic bit_io(input logic b, output logic seen);
    wt(2);
    pull_q = !b;
    wt(3);
    scl_o = 1'b1;
    wt(3);
    seen = sda_o;
    wt(2);
    scl_o = 1'b0;
  endtask : bit_io
  task automatic cond(input logic stop_c);
    wt(2);
    pull_q = stop_c;
    wt(3);
    scl_o = 1'b1;
    wt(5);
    pull_q = !stop_c;
    wt(5);
    scl_o = stop_c;
  endtask : cond
  task automatic xfer(input logic [7:0] wr, input logic mack, output logic [7:0] rd,
                      output logic ok);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(wr[i], rd[i]);
    bit_io(mack, s);
    ok = !s;
  endtask : xfer
  task automatic reg_write(input logic [7:0] p, input logic [7:0] d, output logic ok);
    logic [7:0] x;
    logic a, b, c;
    cond(1'b0);
    xfer({cds_pkg::SLAVE_ADDR, 1'b0}, 1'b1, x, a);
    xfer(p, 1'b1, x, b);
    xfer(d, 1'b1, x, c);
    cond(1'b1);
    ok = a & b & c;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] p, output logic [7:0] d, output logic ok);
    logic [7:0] x;
    logic a, b, c, n;
    cond(1'b0);
    xfer({cds_pkg::SLAVE_ADDR, 1'b0}, 1'b1, x, a);
    xfer(p, 1'b1, x, b);
    cond(1'b0);
    xfer({cds_pkg::SLAVE_ADDR, 1'b1}, 1'b1, x, c);
    xfer(8'hFF, 1'b1, d, n);
    cond(1'b1);
    ok = a & b & c;
  endtask : reg_read
endmodule : cds_host_model

// ===== verif/tb_cds_top.sv
/* Self-checking bench for cds_top, host model on the serial pins.
   Assumes ce_i held high; expectations come from the register rules. */
`timescale 1ns/1ns
module tb_cds_top;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic conv_start_i = 1'b0;
  logic conv_vt_i = 1'b0;
  logic scl, sda, sdo, sda_oe, busy, done, a_o, a_oe, b_o, b_oe;
  logic [1:0] lvl;
  logic [7:0] cfg;
  logic [2:0] snap;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  always #10 clock_i = !clock_i;
  cds_host_model host (.clock_i(clock_i), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
  cds_top DUT (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(1'b1), .scl_i(scl), .sda_i(sda),
    .sda_o(sdo), .sda_oe_o(sda_oe), .conv_start_i(conv_start_i), .conv_vt_i(conv_vt_i),
    .conv_busy_o(busy), .conv_done_o(done), .drv_a_o(a_o), .drv_a_oe_o(a_oe),
    .drv_b_o(b_o), .drv_b_oe_o(b_oe), .drive_level_o(lvl), .converter_config_o(cfg));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string m);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      close_out();
    end
  end
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic ok;
    host.reg_write(p, d, ok);
    check(ok, 1'b1, "write not acked");
  endtask : wr
  task automatic rd(input logic [7:0] p, input logic [7:0] e, input string m);
    logic [7:0] d;
    logic ok;
    host.reg_read(p, d, ok);
    check(ok, 1'b1, "read not acked");
    check(d, e, m);
  endtask : rd
  // n: cycles to done; g: cycles between later pin A toggles; snap taken early on
  task automatic conv(input logic vt, output int n, output int g);
    int k, t0;
    logic last;
    k = 0;
    n = 0;
    g = 0;
    t0 = 0;
    last = a_o;
    conv_vt_i = vt;
    conv_start_i = 1'b1;
    @(negedge clock_i);
    conv_start_i = 1'b0;
    check(busy, 1'b1, "busy after start");
    while (done !== 1'b1 && n < 2000) begin
      @(negedge clock_i);
      n++;
      if (n == 30) snap = {a_oe, b_oe, a_oe & b_oe & (a_o ^ b_o)};
      if (a_o !== last) k++;
      if (a_o !== last && k == 2) t0 = n;
      if (a_o !== last && k == 3) g = n - t0;
      last = a_o;
    end
    @(negedge clock_i);
  endtask : conv
  task automatic near(input int n, input int e, input string m);
    check(n > e - 8 && n < e + 8, 1'b1, m);
  endtask : near
  task automatic t_reset();
    check(lvl, 2'h3, "level after reset");
    check(cfg, 8'hA0, "config after reset");
    check(sdo, 1'b0, "sda drive level");
    rd(8'h09, 8'h03, "setup reset value");
    rd(8'h0A, 8'hA0, "config reset value");
    rd(8'h05, 8'h00, "unmapped read");
    $display("test reset done");
  endtask : t_reset
  task automatic t_regs();
    wr(8'h0A, 8'h5C);
    check(cfg, 8'h5C, "config output");
    rd(8'h0A, 8'h5C, "config readback");
    wr(8'h09, 8'h02);
    check(lvl, 2'h2, "level output");
    wr(8'h05, 8'h77);
    rd(8'h05, 8'h00, "unmapped write dropped");
    rd(8'h09, 8'h02, "setup readback");
    $display("test registers done");
  endtask : t_regs
  task automatic t_pins();
    logic [7:0] set_v [8] = '{8'h28, 8'h24, 8'h18, 8'h14, 8'h00, 8'h28, 8'h68, 8'h20};
    logic [2:0] exp_v [8] = '{3'h6, 3'h7, 3'h7, 3'h6, 3'h0, 3'h0, 3'h6, 3'h2};
    logic [7:0] vt_m = 8'h60;
    int n, g;
    for (int i = 0; i < 8; i++) begin
      wr(8'h09, set_v[i]);
      conv(vt_m[i], n, g);
      check(snap, exp_v[i], "pin enable or polarity");
    end
    $display("test pins done");
  endtask : t_pins
  task automatic t_halve();
    int n, g;
    wr(8'h09, 8'h68);
    conv(1'b0, n, g);
    near(n, 256, "cap time full rate");
    check(g, 4'h4, "drive period full rate");
    conv(1'b1, n, g);
    near(n, 512, "vt time full rate");
    wr(8'h09, 8'hE8);
    conv(1'b0, n, g);
    near(n, 512, "cap time halved");
    check(g, 4'h8, "drive period halved");
    conv(1'b1, n, g);
    near(n, 1024, "vt time halved");
    $display("test halving done");
  endtask : t_halve
  initial begin
    repeat (3) @(negedge clock_i);
    nrst_i = 1'b1;
    repeat (3) @(negedge clock_i);
    t_reset();
    t_regs();
    t_pins();
    t_halve();
    close_out();
  end
endmodule : tb_cds_top
